/* dv/pin_side_model.sv */
// far side of the port: resolves each two-way pin from the port drive and an outside level
`timescale 1ns/1ps
module pin_side_model (
  input  wire port_filter_pkg::pin_drive_s pin_drv,
  input  wire logic [7:0]                  ext_lvl,
  output logic      [7:0]                  pin_in
);
  // a driven pin reads back the port's own level, others show the outside source
  assign pin_in = (~pin_drv.oe_n & pin_drv.out) | (pin_drv.oe_n & ext_lvl);
endmodule

/* dv/port_filter_sva.sv */
// checker for the filtered port, bound to its top module
`timescale 1ns/1ps
module port_filter_sva (
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic [3:0]                  addr,
  input wire logic [7:0]                  wdata,
  input wire logic                        wr,
  input wire logic                        rd,
  input wire logic [7:0]                  rdata,
  input wire logic [7:0]                  pin_in,
  input wire port_filter_pkg::pin_drive_s  pin_drv,
  input wire port_filter_pkg::periph_ctl_s periph,
  input wire logic [7:0]                  ext_data_out,
  input wire logic                        ext_data_drive,
  input wire logic [7:0]                  ext_data_in,
  input wire logic [3:0]                  timer_capture_in,
  input wire logic [7:0]                  key_irq_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  //====================
  // edges since release; past pin levels are only trusted once the sync chain has filled
  logic [1:0] up_reg;
  logic [1:0] up_next;
  always_comb up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) up_reg <= 2'h0;
    else up_reg <= up_next;
  //====================
  // nothing that steers the pins changed
  sequence quiet_s;
    up_reg != 2'h0 && !$past(wr) && $stable(periph) && $stable({ext_data_out, ext_data_drive});
  endsequence
  drive_hold_a: assert property (quiet_s |=> $stable(pin_drv))
    else $error("pin drive moved");
  ext_in_a: assert property (up_reg == 2'h3 |-> ext_data_in == $past(pin_in, 3))
    else $error("bus input wrong");
  capture_route_a: assert property (up_reg == 2'h3 |->
    timer_capture_in == ($past(periph.capture_enable) & $past(pin_in[5:2], 3)))
    else $error("capture input wrong");
  key_input_a: assert property (up_reg == 2'h3 && key_irq_n != 8'hff |->
    key_irq_n == ($past(periph.key_mask) | $past(pin_in, 3)))
    else $error("key input wrong");
  out_b_a: assert property (up_reg != 2'h0 && $past(periph.out_b_enable) |->
    !pin_drv.oe_n[6] && pin_drv.out[6] == $past(periph.out_b_level))
    else $error("compare output not on pin");
  bus_drive_a: assert property ($past(ext_data_drive) && pin_drv.oe_n == 8'h00 |->
    pin_drv.out == $past(ext_data_out))
    else $error("bus data not on pins");
  pins_read_a: assert property (up_reg == 2'h3 && rd && addr == 4'h6 |=>
    rdata == $past(pin_in, 3))
    else $error("pin level read wrong");
  hole_read_a: assert property (rd && addr > 4'h6 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind port_noise_filter_pin_select port_filter_sva chk (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_drv(pin_drv),
  .periph(periph), .ext_data_out(ext_data_out), .ext_data_drive(ext_data_drive),
  .ext_data_in(ext_data_in), .timer_capture_in(timer_capture_in), .key_irq_n(key_irq_n));

/* dv/test_port_noise_filter_pin_select.sv */
// self-checking bench for the filtered port
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module test_port_noise_filter_pin_select;
  logic                         clk, rst_n, wr, rd, xd;
  logic [3:0]                   addr, tcap;
  logic [7:0]                   wdata, rdata, ext_lvl, pin_in, xo, xi, key_n, v;
  port_filter_pkg::pin_drive_s  drv;
  port_filter_pkg::periph_ctl_s per;
  int                           failures = 0, compares = 0, cyc = 0;
  port_noise_filter_pin_select uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_drv(drv), .periph(per),
    .ext_data_out(xo), .ext_data_drive(xd), .ext_data_in(xi), .timer_capture_in(tcap),
    .key_irq_n(key_n));
  pin_side_model far (.pin_drv(drv), .ext_lvl(ext_lvl), .pin_in(pin_in));
  //====================
  // bus cycles; each strobe drops before the next task may raise it
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  //====================
  // reset values, a pin read and a hole in the map
  task automatic t_reset();
    logic [27:0] a;
    logic [55:0] e;
    logic [55:0] m;
    a = 28'hf654321;
    e = 56'h00_00_00_00_ff_00_00;
    m = 56'hff_ff_07_07_ff_ff_ff;
    for (int i = 0; i < 7; i++) begin
      rd_reg(a[i*4 +: 4]);
      `CHK(v & m[i*8 +: 8], e[i*8 +: 8])
    end
  endtask
  // outputs ignore the filter bit; compare output B overrides pin 6
  task automatic t_output();
    wr_reg(4'h1, 8'hff);
    wr_reg(4'h0, 8'ha5);
    wr_reg(4'h2, 8'hff);
    settle(1);
    `CHK(drv, 16'ha500)
    @(posedge clk) per <= 14'h3000;
    settle(2);
    `CHK(drv, 16'he500)
    wr_reg(4'h1, 8'h00);
    settle(1);
    `CHK(drv.oe_n, 8'hbf)
    @(posedge clk) per <= 14'h0000;
    settle(2);
    `CHK(drv.oe_n, 8'hff)
  endtask
  // each capture enable in turn, then a key input under its mask
  task automatic t_capture_key();
    wr_reg(4'h2, 8'h00);
    @(posedge clk) ext_lvl <= 8'hff;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) per <= 14'h0100 << i;
      settle(4);
      `CHK(tcap, 4'h1 << i)
    end
    @(posedge clk) per <= 14'h007f;
    @(posedge clk) ext_lvl <= 8'h7f;
    settle(4);
    `CHK(key_n, 8'h7f)
    @(posedge clk) per <= 14'h0000;
  endtask
  // 16-bit bus takes the pins; 8-bit and multiplexed modes leave them to the port
  task automatic t_modes();
    logic [23:0] md;
    md = 24'h070501;
    wr_reg(4'h1, 8'hff);
    @(posedge clk) ext_lvl <= 8'h3c;
    wr_reg(4'h5, 8'h03);
    // pins show the outside level one edge after release, then two sync stages and the output flop
    settle(4);
    `CHK(drv.oe_n, 8'hff)
    `CHK(xi, 8'h3c)
    @(posedge clk) {xd, xo} <= 9'h15a;
    settle(2);
    `CHK(drv, 16'h5a00)
    @(posedge clk) xd <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      wr_reg(4'h5, md[i*8 +: 8]);
      settle(1);
      `CHK(drv, 16'ha500)
    end
    wr_reg(4'h5, 8'h00);
    wr_reg(4'h1, 8'h00);
  endtask
  // a one-cycle glitch is rejected; a slow period delays the latch by two ticks
  task automatic t_filter();
    @(posedge clk) ext_lvl <= 8'h00;
    wr_reg(4'h2, 8'hff);
    settle(8);
    @(posedge clk) ext_lvl <= 8'hff;
    @(posedge clk) ext_lvl <= 8'h00;
    settle(8);
    rd_reg(4'h0);
    `CHK(v, 8'h00)
    @(posedge clk) ext_lvl <= 8'hff;
    settle(8);
    rd_reg(4'h0);
    `CHK(v, 8'hff)
    wr_reg(4'h3, 8'h00);
    wr_reg(4'h4, 8'h01);
    @(posedge clk) ext_lvl <= 8'h00;
    settle(20);
    rd_reg(4'h0);
    `CHK(v, 8'hff)
    settle(50);
    rd_reg(4'h0);
    `CHK(v, 8'h00)
  endtask
  //====================
  task automatic give_verdict();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    {wr, rd, xd, addr, wdata, xo, ext_lvl, per} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_output();
    t_capture_key();
    t_modes();
    t_filter();
    give_verdict();
  end
endmodule

/* hw/port_filter_defs.svh */
// constants for the filtered port: register offsets, field positions, resets, divider counts
//==============================================================
`ifndef PORT_FILTER_DEFS_SVH
`define PORT_FILTER_DEFS_SVH

//==============================================================
// register offsets (byte addresses on the plain port)
`define OFS_DATA      4'h0
`define OFS_DIR       4'h1
`define OFS_FILT_EN   4'h2
`define OFS_EXPECT    4'h3
`define OFS_PERIOD    4'h4
`define OFS_MODE      4'h5
`define OFS_PINS      4'h6

//==============================================================
// field positions and reset values
`define PERIOD_SEL_LSB   0
`define PERIOD_SEL_MSB   2
`define MODE_EXT_BIT     0
`define MODE_BUS16_BIT   1
`define MODE_MUX_BIT     2
`define RST_DATA         8'h00
`define RST_DIR          8'h00
`define RST_FILT_EN      8'h00
`define RST_EXPECT       8'hff
`define RST_PERIOD_SEL   3'h0
`define RST_MODE         3'h0

//==============================================================
// division ratios per select code, as a power of two
`define DIV_LOG2_0  1
`define DIV_LOG2_1  5
`define DIV_LOG2_2  9
`define DIV_LOG2_3  13
`define DIV_LOG2_4  15
`define DIV_LOG2_5  16
`define DIV_LOG2_6  17
`define DIV_LOG2_7  18
`define DIV_CNT_W   18

`endif

/* hw/port_filter_pkg.sv */
// types shared by the filtered port
package port_filter_pkg;

  // bus mode as seen by the port
  typedef struct packed {
    logic mux;
    logic bus16;
    logic ext;
  } bus_mode_s;

  // peripheral hooks into the pins
  typedef struct packed {
    logic out_b_enable;
    logic out_b_level;
    logic [3:0] capture_enable;
    logic [7:0] key_mask;
  } periph_ctl_s;

  // pin drive bundle
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } pin_drive_s;

endpackage

/* hw/port_noise_filter_pin_select.sv */
// 8-bit port with per-pin noise filter, function select and data bus takeover
`timescale 1ns/1ps
`include "port_filter_defs.svh"

module port_noise_filter_pin_select (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [3:0]                 addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [7:0]                 rdata,
  input  wire logic [7:0]                 pin_in,
  output port_filter_pkg::pin_drive_s     pin_drv,
  input  wire port_filter_pkg::periph_ctl_s periph,
  input  wire logic [7:0]                 ext_data_out,
  input  wire logic                       ext_data_drive,
  output logic      [7:0]                 ext_data_in,
  output logic      [3:0]                 timer_capture_in,
  output logic      [7:0]                 key_irq_n
);

  //==============================================================
  // registers
  logic [7:0]                   data_reg, data_next;
  logic [7:0]                   dir_reg, dir_next;
  logic [7:0]                   filt_en_reg, filt_en_next;
  logic [7:0]                   expect_reg, expect_next;
  logic [2:0]                   period_sel_reg, period_sel_next;
  logic [4:0]                   period_rsv_reg, period_rsv_next;
  port_filter_pkg::bus_mode_s   mode_reg, mode_next;
  logic [7:0]                   rdata_reg, rdata_next;
  logic [7:0]                   sync1_reg, sync2_reg;
  logic [7:0]                   samp_reg, samp_next;
  logic [7:0]                   filt_reg, filt_next;
  logic [`DIV_CNT_W-1:0]        div_reg, div_next;
  logic                         tick_reg, tick_next;
  port_filter_pkg::pin_drive_s  drv_reg, drv_next;
  logic [7:0]                   ext_in_reg;
  logic [3:0]                   cap_reg, cap_next;
  logic [7:0]                   key_reg, key_next;

  // terminal count for the selected division; tick every 2^n cycles
  function automatic logic [`DIV_CNT_W-1:0] div_last(input logic [2:0] sel);
    logic [4:0] sh;
    sh = 5'h0;
    unique case (sel)
      3'h0: sh = 5'(`DIV_LOG2_0);
      3'h1: sh = 5'(`DIV_LOG2_1);
      3'h2: sh = 5'(`DIV_LOG2_2);
      3'h3: sh = 5'(`DIV_LOG2_3);
      3'h4: sh = 5'(`DIV_LOG2_4);
      3'h5: sh = 5'(`DIV_LOG2_5);
      3'h6: sh = 5'(`DIV_LOG2_6);
      3'h7: sh = 5'(`DIV_LOG2_7);
    endcase
    div_last = (`DIV_CNT_W'(1) << sh) - `DIV_CNT_W'(1);
  endfunction

  logic bus_takeover;
  assign bus_takeover = mode_reg.ext & mode_reg.bus16 & ~mode_reg.mux;

  //==============================================================
  // pin synchroniser: first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  //==============================================================
  // register writes and read data
  always_comb begin
    data_next       = data_reg;
    dir_next        = dir_reg;
    filt_en_next    = filt_en_reg;
    expect_next     = expect_reg;
    period_sel_next = period_sel_reg;
    period_rsv_next = period_rsv_reg;
    mode_next       = mode_reg;
    rdata_next      = 8'h00;
    if (wr) begin
      unique case (addr)
        `OFS_DATA:    data_next = wdata;
        `OFS_DIR:     dir_next = wdata;
        `OFS_FILT_EN: filt_en_next = wdata;
        `OFS_EXPECT:  expect_next = wdata;
        `OFS_PERIOD: begin
          period_sel_next = wdata[`PERIOD_SEL_MSB:`PERIOD_SEL_LSB];
          period_rsv_next = wdata[7:3];
        end
        `OFS_MODE:    mode_next = wdata[2:0];
        default: ;
      endcase
    end
    if (rd) begin
      unique case (addr)
        // read of the data latch: outputs show latch, filtered inputs the filter, others the pin
        `OFS_DATA:    rdata_next = (dir_reg & data_reg) | (~dir_reg & filt_en_reg & filt_reg)
                                 | (~dir_reg & ~filt_en_reg & sync2_reg);
        `OFS_DIR:     rdata_next = dir_reg;
        `OFS_FILT_EN: rdata_next = filt_en_reg;
        `OFS_EXPECT:  rdata_next = expect_reg;
        `OFS_PERIOD:  rdata_next = {period_rsv_reg, period_sel_reg};
        `OFS_MODE:    rdata_next = {5'h00, mode_reg};
        `OFS_PINS:    rdata_next = sync2_reg;
        default:      rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg       <= `RST_DATA;
      dir_reg        <= `RST_DIR;
      filt_en_reg    <= `RST_FILT_EN;
      expect_reg     <= `RST_EXPECT;
      period_sel_reg <= `RST_PERIOD_SEL;
      period_rsv_reg <= 5'h00;
      mode_reg       <= `RST_MODE;
      rdata_reg      <= 8'h00;
    end else begin
      data_reg       <= data_next;
      dir_reg        <= dir_next;
      filt_en_reg    <= filt_en_next;
      expect_reg     <= expect_next;
      period_sel_reg <= period_sel_next;
      period_rsv_reg <= period_rsv_next;
      mode_reg       <= mode_next;
      rdata_reg      <= rdata_next;
    end
  end

  //==============================================================
  // sample divider; restarts on a select change so the new period is exact
  always_comb begin
    div_next  = div_reg + `DIV_CNT_W'(1);
    tick_next = 1'b0;
    if (div_reg >= div_last(period_sel_reg)) begin
      div_next  = '0;
      tick_next = 1'b1;
    end
    if (wr && addr == `OFS_PERIOD) begin
      div_next = '0;
    end
  end

  //==============================================================
  // filter: two agreeing samples on successive ticks update the latch
  // only toward the expected level; the other level passes at once
  always_comb begin
    samp_next = samp_reg;
    filt_next = filt_reg;
    if (tick_reg) begin
      samp_next = sync2_reg;
      for (int i = 0; i < 8; i++) begin
        if (sync2_reg[i] == samp_reg[i] && sync2_reg[i] == expect_reg[i]) begin
          filt_next[i] = expect_reg[i];
        end else if (sync2_reg[i] != expect_reg[i]) begin
          filt_next[i] = sync2_reg[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
      samp_reg <= 8'h00;
      filt_reg <= 8'h00;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
      samp_reg <= samp_next;
      filt_reg <= filt_next;
    end
  end

  //==============================================================
  // pin function select; oe_n low while the port drives
  always_comb begin
    drv_next.out  = data_reg;
    drv_next.oe_n = ~dir_reg;
    if (periph.out_b_enable) begin
      drv_next.out[6]  = periph.out_b_level;
      drv_next.oe_n[6] = 1'b0;
    end
    if (bus_takeover) begin
      drv_next.out  = ext_data_out;
      drv_next.oe_n = {8{~ext_data_drive}};
    end
    // capture inputs on pins 5..2; software keeps direction and filter clear
    cap_next = bus_takeover ? 4'h0 : periph.capture_enable & sync2_reg[5:2];
    // key inputs active low; masked or bus-owned pins read idle high
    key_next = (bus_takeover ? 8'hff : (periph.key_mask | sync2_reg));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_reg    <= '{out: 8'h00, oe_n: 8'hff};
      cap_reg    <= 4'h0;
      key_reg    <= 8'hff;
      ext_in_reg <= 8'h00;
    end else begin
      drv_reg    <= drv_next;
      cap_reg    <= cap_next;
      key_reg    <= key_next;
      ext_in_reg <= sync2_reg;
    end
  end

  assign rdata            = rdata_reg;
  assign pin_drv          = drv_reg;
  assign ext_data_in      = ext_in_reg;
  assign timer_capture_in = cap_reg;
  assign key_irq_n        = key_reg;

endmodule
